// file: verilog/sfc_pkg.sv
// Package of constants and types for the serial FIFO configuration block.
package sfc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_RX_CFG = 8'h00;
  localparam logic [7:0] OFF_TX_CFG = 8'h04;
  localparam logic [7:0] OFF_RX_STAT = 8'h08;
  localparam logic [7:0] OFF_TX_STAT = 8'h0C;
  localparam logic [7:0] OFF_SETUP = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam int unsigned CLR_BIT = 7;
  localparam int unsigned TRIG_BIT = 6;
  localparam int unsigned THR_LSB = 0;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned DPX_LSB = 1;
  localparam int unsigned IRQ_RX_BIT = 0;
  localparam int unsigned IRQ_TX_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [2:0] LVL_EMPTY = 3'h0;
  localparam logic [2:0] LVL_ONE = 3'h1;
  localparam logic [2:0] LVL_TWO = 3'h2;
  localparam logic [2:0] LVL_THREE = 3'h3;
  localparam logic [2:0] LVL_FOUR = 3'h4;
  localparam int unsigned DEPTH = 4;
  typedef enum logic [1:0] {
    SFC_DPX_OFF = 2'h0,
    SFC_DPX_HALF_RX = 2'h1,
    SFC_DPX_HALF_TX = 2'h2,
    SFC_DPX_FULL = 2'h3
  } sfc_dpx_t;
endpackage

// file: verilog/sfc_top.sv
// Serial channel FIFO pair with clear commands, thresholds and interrupts.
`timescale 1ns/1ps
module sfc_top
  import sfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [sfc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  input wire logic i_rx_pop,
  output logic [7:0] o_rx_data,
  output logic o_rx_avail,
  input wire logic i_tx_push,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_space,
  input wire logic i_tx_pop,
  output logic [7:0] o_tx_data,
  output logic o_tx_avail,
  output logic o_rx_event,
  output logic o_tx_event,
  output logic o_irq
);
  import sfc_pkg::*;

  logic rst_s1_q, rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic wr_en, rd_en;
  logic rx_trig_q, tx_trig_q, fifo_en_q;
  logic [1:0] rx_thr_q, tx_thr_q, irq_stat_q, irq_mask_q;
  sfc_dpx_t dpx_q;
  logic rx_clr, tx_clr;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign rx_clr = wr_en && i_paddr == OFF_RX_CFG && i_pwdata[CLR_BIT];
  assign tx_clr = wr_en && i_paddr == OFF_TX_CFG && i_pwdata[CLR_BIT];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_trig_q <= 1'b0;
      rx_thr_q <= CFG_RESET;
      tx_trig_q <= 1'b0;
      tx_thr_q <= CFG_RESET;
      fifo_en_q <= 1'b0;
      dpx_q <= SFC_DPX_OFF;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      case (i_paddr)
        OFF_RX_CFG: begin
          rx_trig_q <= i_pwdata[TRIG_BIT];
          rx_thr_q <= i_pwdata[THR_LSB+:2];
        end
        OFF_TX_CFG: begin
          tx_trig_q <= i_pwdata[TRIG_BIT];
          tx_thr_q <= i_pwdata[THR_LSB+:2];
        end
        OFF_SETUP: begin
          fifo_en_q <= i_pwdata[EN_BIT];
          dpx_q <= sfc_dpx_t'(i_pwdata[DPX_LSB+:2]);
        end
        OFF_IRQ_MASK: irq_mask_q <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Depth and thresholds follow the duplex setting.
  logic full_dpx;
  logic [2:0] rx_depth, tx_depth, rx_lvl_thr, tx_lvl_thr;
  assign full_dpx = dpx_q == SFC_DPX_FULL;
  always_comb begin
    rx_depth = LVL_EMPTY;
    tx_depth = LVL_EMPTY;
    if (fifo_en_q) begin
      case (dpx_q)
        SFC_DPX_HALF_RX: rx_depth = LVL_FOUR;
        SFC_DPX_HALF_TX: tx_depth = LVL_FOUR;
        SFC_DPX_FULL: begin
          rx_depth = LVL_TWO;
          tx_depth = LVL_TWO;
        end
        default: ;
      endcase
    end
    case (rx_thr_q)
      2'h0: rx_lvl_thr = full_dpx ? LVL_TWO : LVL_FOUR;
      2'h1: rx_lvl_thr = LVL_ONE;
      2'h2: rx_lvl_thr = LVL_TWO;
      default: rx_lvl_thr = full_dpx ? LVL_ONE : LVL_THREE;
    endcase
    case (tx_thr_q)
      2'h0: tx_lvl_thr = LVL_EMPTY;
      2'h1: tx_lvl_thr = LVL_ONE;
      2'h2: tx_lvl_thr = full_dpx ? LVL_EMPTY : LVL_TWO;
      default: tx_lvl_thr = full_dpx ? LVL_ONE : LVL_THREE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two FIFOs; index 0 is receive, index 1 is transmit.
  logic [2:0] lvl_q [2];
  logic [1:0] wp_q [2];
  logic [1:0] rp_q [2];
  logic [7:0] mem_q [2][DEPTH];
  logic [7:0] out_q [2];
  logic push [2];
  logic pop [2];
  logic clr [2];
  logic [7:0] din [2];
  logic [2:0] dep [2];
  assign push[0] = i_rx_valid && o_rx_ready;
  assign push[1] = i_tx_push && o_tx_space;
  assign pop[0] = i_rx_pop && o_rx_avail;
  assign pop[1] = i_tx_pop && o_tx_avail;
  assign clr[0] = rx_clr;
  assign clr[1] = tx_clr;
  assign din[0] = i_rx_data;
  assign din[1] = i_tx_data;
  assign dep[0] = rx_depth;
  assign dep[1] = tx_depth;

  for (genvar f = 0; f < 2; f++) begin : g_fifo
    logic [2:0] lvl_d;
    always_comb begin
      lvl_d = lvl_q[f];
      if (push[f] && !pop[f]) lvl_d = lvl_q[f] + 3'h1;
      if (pop[f] && !push[f]) lvl_d = lvl_q[f] - 3'h1;
    end
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        lvl_q[f] <= LVL_EMPTY;
        wp_q[f] <= 2'h0;
        rp_q[f] <= 2'h0;
      end else if (clr[f]) begin
        lvl_q[f] <= LVL_EMPTY;
        wp_q[f] <= 2'h0;
        rp_q[f] <= 2'h0;
      end else begin
        lvl_q[f] <= lvl_d;
        if (push[f]) wp_q[f] <= wp_q[f] + 2'h1;
        if (pop[f]) rp_q[f] <= rp_q[f] + 2'h1;
      end
    end
    always_ff @(posedge i_clk) begin
      if (push[f]) mem_q[f][wp_q[f]] <= din[f];
    end
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) out_q[f] <= 8'h00;
      else out_q[f] <= mem_q[f][rp_q[f]];
    end
  end

  // Head word is registered a cycle after it lands, so avail waits for it.
  logic [1:0] head_ok_q;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) head_ok_q <= 2'h0;
    else begin
      head_ok_q[0] <= lvl_q[0] != LVL_EMPTY && !pop[0] && !clr[0];
      head_ok_q[1] <= lvl_q[1] != LVL_EMPTY && !pop[1] && !clr[1];
    end
  end
  assign o_rx_ready = lvl_q[0] < dep[0] && !rx_clr;
  assign o_tx_space = lvl_q[1] < dep[1] && !tx_clr;
  assign o_rx_avail = head_ok_q[0] && lvl_q[0] != LVL_EMPTY;
  assign o_tx_avail = head_ok_q[1] && lvl_q[1] != LVL_EMPTY;
  assign o_rx_data = out_q[0];
  assign o_tx_data = out_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Trigger events: one-cycle pulses from the level change.
  logic rx_hit, tx_hit;
  assign rx_hit = (push[0] && !pop[0] && lvl_q[0] + 3'h1 == rx_lvl_thr)
    || (rx_trig_q && pop[0] && lvl_q[0] - 3'h1 > rx_lvl_thr);
  assign tx_hit = (pop[1] && !push[1] && lvl_q[1] - 3'h1 == tx_lvl_thr)
    || (tx_trig_q && pop[1] && lvl_q[1] - 3'h1 < tx_lvl_thr);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_event <= 1'b0;
      o_tx_event <= 1'b0;
    end else begin
      o_rx_event <= rx_hit && !rx_clr && fifo_en_q;
      o_tx_event <= tx_hit && !tx_clr && fifo_en_q;
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) irq_stat_q <= 2'h0;
    else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_en && i_paddr == OFF_IRQ_STAT && i_pwdata[b])
          irq_stat_q[b] <= 1'b0;
      end
      if (o_rx_event) irq_stat_q[IRQ_RX_BIT] <= 1'b1;
      if (o_tx_event) irq_stat_q[IRQ_TX_BIT] <= 1'b1;
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle and held through the access
  // cycle, so the bus sees a register output with no wait state.
  logic [31:0] rd_word;
  always_comb begin
    case (i_paddr)
      OFF_RX_CFG: rd_word = {24'h0, 1'b0, rx_trig_q, 4'h0, rx_thr_q};
      OFF_TX_CFG: rd_word = {24'h0, 1'b0, tx_trig_q, 4'h0, tx_thr_q};
      OFF_RX_STAT: rd_word = {29'h0, lvl_q[0]};
      OFF_TX_STAT: rd_word = {29'h0, lvl_q[1]};
      OFF_SETUP: rd_word = {29'h0, dpx_q, fifo_en_q};
      OFF_IRQ_STAT: rd_word = {30'h0, irq_stat_q};
      OFF_IRQ_MASK: rd_word = {30'h0, irq_mask_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite) o_prdata <= rd_word;
    else o_prdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear commands empty the FIFO and rewind both its read and write pointers.
  rx_clear_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    rx_clr |=> lvl_q[0] == LVL_EMPTY && rp_q[0] == 2'h0)
    else $error("rx clear failed");
  tx_clear_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    tx_clr |=> lvl_q[1] == LVL_EMPTY && wp_q[1] == 2'h0)
    else $error("tx clear failed");
  rx_trig_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (fifo_en_q && push[0] && !pop[0] && !rx_clr
     && lvl_q[0] + 3'h1 == rx_lvl_thr) |=> o_rx_event)
    else $error("rx threshold event missing");
  rx_over_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (fifo_en_q && rx_trig_q && pop[0] && !rx_clr
     && lvl_q[0] - 3'h1 > rx_lvl_thr) |=> o_rx_event)
    else $error("rx read event missing");
  rx_thr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (full_dpx && rx_thr_q == 2'h0) |-> rx_lvl_thr == LVL_TWO)
    else $error("rx threshold decode wrong");
  tx_thr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (full_dpx && tx_thr_q == 2'h2) |-> tx_lvl_thr == LVL_EMPTY)
    else $error("tx threshold decode wrong");
  tx_reach_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (fifo_en_q && pop[1] && !push[1] && !tx_clr
     && lvl_q[1] - 3'h1 == tx_lvl_thr) |=> o_tx_event)
    else $error("tx threshold event missing");
  tx_trig_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (fifo_en_q && tx_trig_q && pop[1] && !tx_clr
     && lvl_q[1] - 3'h1 < tx_lvl_thr) |=> o_tx_event)
    else $error("tx trigger event missing");
  fifo_depth_a: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    lvl_q[0] <= LVL_FOUR && (!full_dpx || lvl_q[1] <= LVL_TWO))
    else $error("fifo over depth");
  no_room_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !fifo_en_q |-> !o_rx_ready && !o_tx_space)
    else $error("disabled fifo accepts data");
  clr_read_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (rd_en && i_paddr == OFF_RX_CFG) |-> o_prdata[CLR_BIT] == 1'b0)
    else $error("clear bit read back");
  irq_raise_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_rx_event && irq_mask_q[IRQ_RX_BIT] |=> o_irq)
    else $error("interrupt not raised");
  stat_set_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_tx_event |=> irq_stat_q[IRQ_TX_BIT])
    else $error("tx status not set");
  fill_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    lvl_q[0] == LVL_FOUR);
  clear_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    tx_clr && lvl_q[1] != LVL_EMPTY);
  irq_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_irq));
  full_tx_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    full_dpx && lvl_q[1] == LVL_TWO);
  tx_read_c: cover property (@(posedge i_clk) disable iff (!rst_n)
    tx_trig_q && o_tx_event);
endmodule

// file: tb/sfc_top_bench.sv
// Self-checking bench for the serial FIFO configuration block.
`timescale 1ns/1ps
module sfc_top_bench;
  import sfc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic rxv = 1'b0, rxp = 1'b0, txpu = 1'b0, txpo = 1'b0;
  logic [7:0] paddr = 8'h00, rxd = 8'h00, txd = 8'h00, rx_o, tx_o;
  logic [31:0] pwd = 32'h0, prd, rd, seed = 32'h43;
  logic rdy, pslv, rx_rdy, rx_av, tx_sp, tx_av, rx_e, tx_e, irq;
  logic [7:0] q [2][$];
  int errors = 0, compares = 0, ev [2], b, got, lv;
  sfc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(pslv), .i_rx_valid(rxv),
    .i_rx_data(rxd), .o_rx_ready(rx_rdy), .i_rx_pop(rxp), .o_rx_data(rx_o),
    .o_rx_avail(rx_av), .i_tx_push(txpu), .i_tx_data(txd),
    .o_tx_space(tx_sp), .i_tx_pop(txpo), .o_tx_data(tx_o),
    .o_tx_avail(tx_av), .o_rx_event(rx_e), .o_tx_event(tx_e), .o_irq(irq));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  // Event pulses are counted so scenarios compare totals, not exact edges.
  always @(posedge i_clk) begin
    if (rx_e === 1'b1) ev[0] <= ev[0] + 1;
    if (tx_e === 1'b1) ev[1] <= ev[1] + 1;
  end
  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int thr(input int s, input logic f, input logic [1:0] c);
    if (f) return c[0] ? 1 : (s ? 0 : 2);
    return (c == 2'h0 && s == 0) ? 4 : c;
  endfunction
  // A negative depth marks a direction whose size is left open.
  function automatic int dep(input logic [2:0] m, input int s);
    if (!m[0] || m[2:1] == 2'h0) return 0;
    if (m[2:1] == 2'h3) return 2;
    return (m[2:1] == s + 1) ? 4 : -1;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    errors++;
    wrap_up();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if (rdy === 1'b1) break;
    end
    if (i == 20) hang();
    rd = prd;
    chk(pslv, 1'b0);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic burst(input int s, input int c, output int n);
    n = 0;
    for (int i = 0; i <= c; i++) begin
      @(posedge i_clk);
      if (i > 0 && (s ? tx_sp : rx_rdy) === 1'b1) begin
        q[s].push_back(s ? txd : rxd);
        n++;
      end
      rxd <= 8'(xs());
      txd <= 8'(xs());
      if (s) txpu <= (i < c);
      else rxv <= (i < c);
    end
  endtask
  task automatic pop(input int s);
    int i;
    @(posedge i_clk);
    if (s) txpo <= 1'b1;
    else rxp <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if ((s ? tx_av : rx_av) === 1'b1) break;
    end
    if (i == 20) hang();
    chk(s ? tx_o : rx_o, q[s].pop_front());
    rxp <= 1'b0;
    txpo <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] m, r, t);
    apb(1'b1, OFF_SETUP, m);
    apb(1'b1, OFF_RX_CFG, r | 32'h80);
    apb(1'b1, OFF_TX_CFG, t | 32'h80);
    q[0].delete();
    q[1].delete();
  endtask
  task automatic irq_is(input logic e);
    #1;
    chk(irq, e);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, s ? OFF_TX_CFG : OFF_RX_CFG, 32'hFFFFFFFF);
      apb(1'b0, s ? OFF_TX_CFG : OFF_RX_CFG, 32'h0);
      chk(rd, 32'h43);
    end
    for (int m = 0; m < 8; m++) begin
      cfg(m, 32'h0, 32'h0);
      for (int s = 0; s < 2; s++) begin
        burst(s, 6, got);
        apb(1'b0, s ? OFF_TX_STAT : OFF_RX_STAT, 32'h0);
        if (dep(m, s) >= 0) begin
          chk(got, dep(m, s));
          chk(rd, dep(m, s));
        end
        apb(1'b1, s ? OFF_TX_CFG : OFF_RX_CFG, 32'h80);
        apb(1'b0, s ? OFF_TX_STAT : OFF_RX_STAT, 32'h0);
        chk(rd, 32'h0);
        q[s].delete();
      end
    end
    apb(1'b1, OFF_TX_CFG, 32'h41);
    apb(1'b0, OFF_TX_CFG, 32'h0);
    chk(rd, 32'h41);
    for (int k = 0; k < 16; k++) begin
      logic f, tg;
      logic [1:0] cd;
      f = k[3];
      tg = k[2];
      cd = k[1:0];
      cfg(f ? 7 : 3, {tg, 4'h0, cd}, 32'h0);
      b = ev[0];
      for (int i = 1; i <= (f ? 2 : 4); i++) begin
        burst(0, 1, got);
        repeat (3) @(posedge i_clk);
        chk(ev[0] - b, i >= thr(0, f, cd));
      end
      pop(0);
      repeat (3) @(posedge i_clk);
      chk(ev[0] - b, 1 + (tg && (f ? 1 : 3) > thr(0, f, cd)));
      cfg(f ? 7 : 5, 32'h0, {tg, 4'h0, cd});
      burst(1, f ? 2 : 4, got);
      b = ev[1];
      lv = 0;
      for (int l = (f ? 1 : 3); l >= 0; l--) begin
        pop(1);
        repeat (3) @(posedge i_clk);
        lv += (l == thr(1, f, cd)) || (tg && l < thr(1, f, cd));
        chk(ev[1] - b, lv);
      end
    end
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    irq_is(1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h3);
    irq_is(1'b1);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    irq_is(1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    apb(1'b1, OFF_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    wrap_up();
  end
endmodule
